// >>> isc_channel_config.sv
// Overview of operation
// - Bit 7 of each channel setup register picks the lower (0) or higher (1) loss range.
// - Bits 6:5 of each setup register pick the band: 0 low, 1 middle, 2 high.
// - Setup bits 4:0, the cycle count, with the shared divider set the sampling window.
// - Tracking bits 2:1 set how fast channel 0 baseline follows a negative processed value.
// - The channel 0 tracking register resets to DA, its reserved upper bits to 1B.
// - The channel 0 setup register at 20 resets to 04.
// - Setup registers of channels 1 to 3 sit at 22, 24, 26 with the same layout and reset 04.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps

module isc_channel_config
	import isc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic [NUM_CH-1:0]             conv_start,
	input  wire logic [NUM_CH-1:0]             conv_done,
	input  wire logic [DIV_W-1:0]              window_divider,
	input  wire logic signed [VAL_W-1:0]       processed_button_value,
	output logic [NUM_CH-1:0]                  loss_range_select,
	output logic [NUM_CH-1:0][1:0]             frequency_band_select,
	output logic [NUM_CH-1:0][WIN_W-1:0]       window_length,
	output logic [1:0]                         fast_baseline_factor,
	output logic                               fast_track_active
);

	initial begin
		if (ADDR_W < 8 || ADDR_W > 32)
			$error("ADDR_W must lie between 8 and 32");
	end

	typedef struct packed {
		logic                   awready;
		logic                   wready;
		logic [ADDR_W-1:0]      awaddr;
		logic                   aw_got;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   w_got;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic [NUM_CH-1:0][7:0] setup;
		logic [7:0]             track;
		logic [1:0]             factor;
		logic                   factor_act;
	} isc_regs_type;

	isc_regs_type        s_q;
	isc_regs_type        s_d;
	logic [NUM_CH-1:0]   active;
	logic                wr_fire;
	logic [ADDR_W-3:0]   wr_idx;
	logic [ADDR_W-3:0]   rd_idx;

	assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign wr_idx  = s_q.awaddr[ADDR_W-1:2];
	assign rd_idx  = s_axi_araddr[ADDR_W-1:2];

	// ==========================================================
	// Register file and AXI4-Lite slave
	always_comb begin
		s_d = s_q;
		// Address and data may arrive in either order; each is held until both are in
		if (s_q.awready && s_axi_awvalid) begin
			s_d.awaddr = s_axi_awaddr;
			s_d.aw_got = 1'b1;
		end
		if (s_q.wready && s_axi_wvalid) begin
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
			s_d.w_got = 1'b1;
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_SLVERR;
			for (int i = 0; i < NUM_CH; i++) begin
				if (wr_idx == (ADDR_W-2)'(IDX_SETUP[i])) begin
					s_d.bresp = RESP_OKAY;
					if (s_q.wstrb[0])
						s_d.setup[i] = s_q.wdata[7:0];
				end
			end
			if (wr_idx == (ADDR_W-2)'(IDX_TRACK)) begin
				s_d.bresp = RESP_OKAY;
				if (s_q.wstrb[0])
					s_d.track = s_q.wdata[7:0];
			end
		end
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready  = !s_d.w_got && !s_d.bvalid;

		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_q.arready && s_axi_arvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = 32'h0000_0000;
			s_d.rresp  = RESP_SLVERR;
			for (int i = 0; i < NUM_CH; i++) begin
				if (rd_idx == (ADDR_W-2)'(IDX_SETUP[i])) begin
					s_d.rdata = {24'h00_0000, s_q.setup[i]};
					s_d.rresp = RESP_OKAY;
				end
			end
			if (rd_idx == (ADDR_W-2)'(IDX_TRACK)) begin
				s_d.rdata = {24'h00_0000, s_q.track};
				s_d.rresp = RESP_OKAY;
			end
			if (rd_idx == (ADDR_W-2)'(IDX_STATUS)) begin
				s_d.rdata = {28'h000_0000, active};
				s_d.rresp = RESP_OKAY;
			end
		end
		s_d.arready = !s_d.rvalid;

		// Factor applies only while the processed value sits below the baseline
		s_d.factor_act = processed_button_value < 0;
		s_d.factor     = s_d.factor_act ? s_q.track[FACTOR_HI:FACTOR_LO] : 2'h0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q         <= '0;
			s_q.awready <= 1'b1;
			s_q.wready  <= 1'b1;
			s_q.arready <= 1'b1;
			s_q.setup   <= {NUM_CH{SETUP_RST}};
			s_q.track   <= TRACK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready        = s_q.awready;
	assign s_axi_wready         = s_q.wready;
	assign s_axi_bvalid         = s_q.bvalid;
	assign s_axi_bresp          = s_q.bresp;
	assign s_axi_arready        = s_q.arready;
	assign s_axi_rvalid         = s_q.rvalid;
	assign s_axi_rdata          = s_q.rdata;
	assign s_axi_rresp          = s_q.rresp;
	assign fast_baseline_factor = s_q.factor;
	assign fast_track_active    = s_q.factor_act;

	// ==========================================================
	// Per-channel settings, latched at conversion start
	// Band code 3 is passed on unchanged; software is trusted to avoid it
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		isc_channel_latch u_latch (
			.aclk                  (aclk),
			.aresetn               (aresetn),
			.conv_start            (conv_start[c]),
			.conv_done             (conv_done[c]),
			.setup_cfg             (s_q.setup[c]),
			.window_divider        (window_divider),
			.conv_active           (active[c]),
			.loss_range_select     (loss_range_select[c]),
			.frequency_band_select (frequency_band_select[c]),
			.window_length         (window_length[c])
		);
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [NUM_CH:0] wr_seen_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_seen_q <= '0;
		end else if (wr_fire && s_q.wstrb[0]) begin
			for (int i = 0; i < NUM_CH; i++)
				if (wr_idx == (ADDR_W-2)'(IDX_SETUP[i]))
					wr_seen_q[i] <= 1'b1;
			if (wr_idx == (ADDR_W-2)'(IDX_TRACK))
				wr_seen_q[NUM_CH] <= 1'b1;
		end
	end

	a_ch0_reset_value: assert property (!wr_seen_q[0] |-> s_q.setup[0] == 8'h04)
		else $error("channel 0 setup lost its reset value");
	a_track_reset: assert property (!wr_seen_q[4] |-> s_q.track == 8'hDA)
		else $error("tracking register lost its reset value");
	a_track_reserved: assert property (!wr_seen_q[4] |-> s_q.track[7:3] == 5'h1B)
		else $error("tracking reserved bits not at reset value");
	a_other_resets: assert property ((wr_seen_q[1] || s_q.setup[1] == SETUP_RST) &&
		(wr_seen_q[2] || s_q.setup[2] == SETUP_RST) && (wr_seen_q[3] || s_q.setup[3] == SETUP_RST))
		else $error("channel 1, 2 or 3 setup lost its reset value");
	a_ch1_offset: assert property (wr_fire && s_q.wstrb[0] && s_q.awaddr == 8'h88 |=>
		s_q.setup[1] == $past(s_q.wdata[7:0]) && $stable(s_q.setup[0]))
		else $error("write to 0x88 did not land in channel 1 setup");
	a_ch3_readback: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h98 |=>
		s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(s_q.setup[3])})
		else $error("read of 0x98 did not return channel 3 setup");
	a_fast_factor: assert property (processed_button_value < 0 |=>
		fast_track_active && fast_baseline_factor == $past(s_q.track[2:1]))
		else $error("fast factor not applied to negative value");
	a_factor_idle: assert property (processed_button_value >= 0 |=> fast_baseline_factor == 2'h0)
		else $error("fast factor applied to non-negative value");
	a_resp_follows: assert property (s_q.aw_got && s_q.w_got && !s_axi_bvalid |=> s_axi_bvalid)
		else $error("write response did not follow address and data");

	c_write_ch0: cover property (wr_fire && s_q.awaddr == 8'h80 ##1 s_axi_bvalid);
	c_read_track: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h94);
	c_negative: cover property (fast_track_active && fast_baseline_factor == 2'h3);

endmodule : isc_channel_config

// >>> isc_channel_latch.sv
`timescale 1ns/1ps

module isc_channel_latch
	import isc_pkg::*;
#(
	parameter int CH_CNT_W = CNT_W,
	parameter int CH_DIV_W = DIV_W,
	parameter int CH_WIN_W = WIN_W
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                conv_start,
	input  wire logic                conv_done,
	input  wire logic [7:0]          setup_cfg,
	input  wire logic [CH_DIV_W-1:0] window_divider,
	output logic                     conv_active,
	output logic                     loss_range_select,
	output logic [1:0]               frequency_band_select,
	output logic [CH_WIN_W-1:0]      window_length
);

	initial begin
		if (CH_WIN_W < CH_CNT_W + (1 << CH_DIV_W) - 1)
			$error("window_length too narrow for count and divider");
	end

	typedef struct packed {
		logic                active;
		logic                range;
		logic [1:0]          band;
		logic [CH_WIN_W-1:0] win;
	} isc_latch_type;

	isc_latch_type s_q;
	isc_latch_type s_d;
	logic          take;

	// ==========================================================
	// Settings are sampled only when a conversion begins
	assign take = conv_start && (!s_q.active || conv_done);

	always_comb begin
		s_d = s_q;
		if (take) begin
			s_d.active = 1'b1;
			s_d.range  = setup_cfg[RANGE_BIT];
			s_d.band   = setup_cfg[BAND_HI:BAND_LO];
			s_d.win    = CH_WIN_W'(setup_cfg[CNT_HI:CNT_LO]) << window_divider;
		end else if (conv_done) begin
			s_d.active = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q.active <= 1'b0;
			s_q.range  <= SETUP_RST[RANGE_BIT];
			s_q.band   <= SETUP_RST[BAND_HI:BAND_LO];
			s_q.win    <= CH_WIN_W'(SETUP_RST[CNT_HI:CNT_LO]);
		end else begin
			s_q <= s_d;
		end
	end

	assign conv_active           = s_q.active;
	assign loss_range_select     = s_q.range;
	assign frequency_band_select = s_q.band;
	assign window_length         = s_q.win;

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_range_applied: assert property (take |=> loss_range_select == $past(setup_cfg[RANGE_BIT]))
		else $error("loss range not taken at conversion start");
	a_band_applied: assert property (take |=> frequency_band_select == $past(setup_cfg[6:5]))
		else $error("frequency band not taken at conversion start");
	a_window_scaled: assert property (take |=>
		window_length == CH_WIN_W'($past(setup_cfg[CNT_HI:CNT_LO])) << $past(window_divider))
		else $error("window length not count shifted by divider");
	a_held_in_conv: assert property (conv_active && !conv_done |=>
		$stable(window_length) && $stable(frequency_band_select) && $stable(loss_range_select))
		else $error("settings changed during a conversion");

	c_restart: cover property (conv_done && conv_start ##1 conv_active);

endmodule : isc_channel_latch

// >>> isc_pkg.sv
package isc_pkg;

	// ==========================================================
	// Geometry
	localparam int NUM_CH = 4;
	localparam int CNT_W  = 5;
	localparam int DIV_W  = 3;
	localparam int WIN_W  = 12;
	localparam int VAL_W  = 16;
	localparam int IDX_W  = 6;

	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [NUM_CH-1:0][IDX_W-1:0] IDX_SETUP = {6'h26, 6'h24, 6'h22, 6'h20};
	localparam logic [IDX_W-1:0]             IDX_TRACK  = 6'h25;
	localparam logic [IDX_W-1:0]             IDX_STATUS = 6'h27;

	// ==========================================================
	// Field positions
	localparam int RANGE_BIT = 7;
	localparam int BAND_HI   = 6;
	localparam int BAND_LO   = 5;
	localparam int CNT_HI    = 4;
	localparam int CNT_LO    = 0;
	localparam int FACTOR_HI = 2;
	localparam int FACTOR_LO = 1;
	localparam int RSV_HI    = 7;
	localparam int RSV_LO    = 3;

	// ==========================================================
	// Reset values and bus answers
	localparam logic [7:0] SETUP_RST     = 8'h04;
	localparam logic [7:0] TRACK_RST     = 8'hDA;
	localparam logic [4:0] TRACK_RSV_RST = 5'h1B;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage : isc_pkg

// >>> test_inductive_sensor_channel_config.sv
`timescale 1ns/1ps

module test_inductive_sensor_channel_config
	import isc_pkg::*;
;
	// ==========================================================
	// Bench signals
	logic                          aclk;
	logic                          aresetn;
	logic [7:0]                    awaddr;
	logic                          awvalid;
	logic [31:0]                   wdata;
	logic [3:0]                    wstrb;
	logic                          wvalid;
	logic                          bready;
	logic [7:0]                    araddr;
	logic                          arvalid;
	logic                          rready;
	logic                          awready;
	logic                          wready;
	logic [1:0]                    bresp;
	logic                          bvalid;
	logic                          arready;
	logic [31:0]                   rdata;
	logic [1:0]                    rresp;
	logic                          rvalid;
	logic [NUM_CH-1:0]             conv_start;
	logic [NUM_CH-1:0]             conv_done;
	logic [DIV_W-1:0]              window_divider;
	logic signed [VAL_W-1:0]       pbv;
	logic [NUM_CH-1:0]             loss_range_select;
	logic [NUM_CH-1:0][1:0]        frequency_band_select;
	logic [NUM_CH-1:0][WIN_W-1:0]  window_length;
	logic [1:0]                    fast_baseline_factor;
	logic                          fast_track_active;
	int                            num_errors;
	int                            n_tests;
	logic [31:0]                   rd;
	logic [1:0]                    rs;
	logic [7:0]                    v;
	// Band fields kept below the reserved code
	logic [7:0]                    setv [NUM_CH] = '{8'h9F, 8'h25, 8'hC3, 8'h41};
	logic [2:0]                    divs [NUM_CH] = '{3'h0, 3'h2, 3'h4, 3'h7};

	isc_channel_config dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .conv_start(conv_start), .conv_done(conv_done),
		.window_divider(window_divider), .processed_button_value(pbv),
		.loss_range_select(loss_range_select), .frequency_band_select(frequency_band_select),
		.window_length(window_length), .fast_baseline_factor(fast_baseline_factor),
		.fast_track_active(fast_track_active)
	);

	always #12.5 aclk = ~aclk;

	// ==========================================================
	// Tasks
	task automatic stop_test;
		$display("Comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Each channel held until its own ready, response waited for under a bound
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 50) begin
			num_errors++;
			stop_test();
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 50) begin
			num_errors++;
			stop_test();
		end
	endtask : axi_rd

	task automatic pulse(input logic [3:0] st, input logic [3:0] dn, input logic [2:0] dv);
		@(posedge aclk);
		conv_start     <= st;
		conv_done      <= dn;
		window_divider <= dv;
		@(posedge aclk);
		conv_start <= '0;
		conv_done  <= '0;
		#1;
	endtask : pulse

	task automatic chk_out(input int c, input logic [7:0] s, input logic [2:0] dv);
		check(32'(loss_range_select[c]), 32'(s[7]));
		check(32'(frequency_band_select[c]), 32'(s[6:5]));
		check(32'(window_length[c]), 32'(WIN_W'(s[4:0]) << dv));
	endtask : chk_out

	// ==========================================================
	// Main sequence
	initial begin
		aclk = 1'b0; aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0;
		wstrb = 4'hF; wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0;
		rready = 1'b0; conv_start = '0; conv_done = '0; window_divider = '0; pbv = '0;
		num_errors = 0; n_tests = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int c = 0; c < NUM_CH; c++) begin
			axi_rd({IDX_SETUP[c], 2'b00}, rd, rs);
			check(rd, 32'h0000_0004);
			check(32'(rs), 32'(RESP_OKAY));
			chk_out(c, SETUP_RST, 3'h0);
		end
		axi_rd({IDX_TRACK, 2'b00}, rd, rs);
		check(rd, 32'h0000_00DA);
		check(32'(rd[7:3]), 32'h0000_001B);
		// Write during a conversion must wait for the next start
		for (int c = 0; c < NUM_CH; c++) begin
			v = setv[c];
			axi_wr({IDX_SETUP[c], 2'b00}, {24'h0, v}, rs);
			check(32'(rs), 32'(RESP_OKAY));
			axi_rd({IDX_SETUP[c], 2'b00}, rd, rs);
			check(rd, {24'h0, v});
			pulse(4'(1 << c), 4'h0, divs[c]);
			chk_out(c, v, divs[c]);
			axi_rd({IDX_STATUS, 2'b00}, rd, rs);
			check(rd, 32'(1 << c));
			axi_wr({IDX_SETUP[c], 2'b00}, {24'h0, v ^ 8'h81}, rs);
			check(32'(loss_range_select[c]), 32'(v[7]));
			check(32'(window_length[c]), 32'(WIN_W'(v[4:0]) << divs[c]));
			// A start while busy without done is ignored
			pulse(4'(1 << c), 4'h0, divs[c]);
			chk_out(c, v, divs[c]);
			pulse(4'(1 << c), 4'(1 << c), divs[c]);
			chk_out(c, v ^ 8'h81, divs[c]);
			pulse(4'h0, 4'(1 << c), divs[c]);
		end
		axi_rd({IDX_STATUS, 2'b00}, rd, rs);
		check(rd, 32'h0000_0000);
		// Every tracking code, reserved bits written back unchanged
		for (int f = 0; f < 4; f++) begin
			axi_wr({IDX_TRACK, 2'b00}, {24'h0, TRACK_RSV_RST, 2'(f), 1'b0}, rs);
			axi_rd({IDX_TRACK, 2'b00}, rd, rs);
			check(rd, {24'h0, TRACK_RSV_RST, 2'(f), 1'b0});
			@(posedge aclk);
			pbv <= 16'sh8000;
			repeat (2) @(posedge aclk);
			#1;
			check(32'(fast_baseline_factor), 32'(f));
			check(32'(fast_track_active), 32'h0000_0001);
			@(posedge aclk);
			pbv <= 16'sh0010;
			repeat (2) @(posedge aclk);
			#1;
			check(32'(fast_baseline_factor), 32'h0000_0000);
			check(32'(fast_track_active), 32'h0000_0000);
		end
		// Holes in the map and the read-only status word
		axi_rd(8'h84, rd, rs);
		check(32'(rs), 32'(RESP_SLVERR));
		check(rd, 32'h0000_0000);
		axi_wr(8'hA0, 32'h0000_00FF, rs);
		check(32'(rs), 32'(RESP_SLVERR));
		axi_wr({IDX_STATUS, 2'b00}, 32'h0000_000F, rs);
		check(32'(rs), 32'(RESP_SLVERR));
		// Low byte strobe off: accepted but nothing changes
		wstrb <= 4'hE;
		axi_wr({IDX_SETUP[0], 2'b00}, 32'h0000_0000, rs);
		check(32'(rs), 32'(RESP_OKAY));
		wstrb <= 4'hF;
		axi_rd({IDX_SETUP[0], 2'b00}, rd, rs);
		check(rd, {24'h0, setv[0] ^ 8'h81});
		stop_test();
	end

endmodule : test_inductive_sensor_channel_config
